/* rtl/ser_regs.svh */
// Register offsets, reset values and sizes of the output event router.
`ifndef SER_REGS_SVH
`define SER_REGS_SVH

`define SER_OFF_SENSE       16'h03ca
`define SER_OFF_SHORT       16'h03d3
`define SER_OFF_COUNTDOWN   16'h03d4
`define SER_OFF_PROGRAM     16'h03d5
`define SER_OFF_INPUT_ONE   16'h03d6
`define SER_OFF_INPUT_TWO   16'h03d7
`define SER_OFF_HOURS       16'h03d9
`define SER_OFF_CYCLES      16'h03da
`define SER_OFF_MSG_STATUS  16'h03dc

`define SER_RST_ENABLE      1'b0
`define SER_RST_SENSE       1'b0
`define SER_MSG_COUNT       7

`endif

/* rtl/ser_pkg.sv */
// Types shared by the output event router.
package ser_pkg;

    // Raw status conditions from the controller core, same clock domain.
    typedef struct packed {
        logic heat_current_sensed;
        logic ctrl_output_on;
        logic timer_mode_cfg;
        logic timer_expired;
        logic program_ctrl_cfg;
        logic program_done;
        logic first_analog_input_fault;
        logic second_analog_input_fault;
        logic hours_preset_reached;
        logic cycles_preset_reached;
    } ser_src_t;

    // One bit per routable message; bit order matches the enable vector.
    typedef struct packed {
        logic short_circuit_route;
        logic countdown_done;
        logic program_finished;
        logic input_one_fault_route;
        logic input_two_fault_route;
        logic hours_limit;
        logic cycles_limit;
    } ser_msg_t;

    // Operating sense of the switching output.
    typedef enum logic [0:0] {
        SER_SENSE_DIRECT  = 1'b0,
        SER_SENSE_INVERSE = 1'b1
    } ser_sense_t;

endpackage

/* rtl/ser_router.sv */
// Switching output event router with its parameter registers.
//
// Function
// - SSR short alarm: heating current sensed while output is off.
// - Short route enable 0 ignores alarm; set, alarm switches output.
// - Timer message only when timer mode configured and time elapsed.
// - Timer route enable 0 inactive, 1 active; active routes message.
// - Program-end message when program finished, only in program mode.
// - Program-end enable 0 ignores message; set, it activates output.
// - First analog input fault switches output when its enable is 1.
// - Second analog input fault switches output when its enable is 1.
// - Hours preset reached gives first info status, routed when enabled.
// - Cycles preset reached gives second info status, routed if enabled.
// - Direct sense: active function sets output on; inverse sets it off.
`timescale 1ns/10ps
`include "ser_regs.svh"

module ser_router (
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic             ce,
    input  wire ser_pkg::ser_src_t src,
    input  wire logic [15:0]      reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [15:0]      reg_wdata,
    output logic      [15:0]      reg_rdata,
    output logic                  switch_out
);

    ////////////////////////////////////////////////////////////////////////
    // Message generation.

    ser_pkg::ser_msg_t  next_msg;
    ser_pkg::ser_msg_t  msg_q;

    // Current while the output is off means the relay is welded or shorted.
    assign next_msg.short_circuit_route   = src.heat_current_sensed
                                          & ~src.ctrl_output_on;
    assign next_msg.countdown_done        = src.timer_mode_cfg
                                          & src.timer_expired;
    assign next_msg.program_finished      = src.program_ctrl_cfg
                                          & src.program_done;
    assign next_msg.input_one_fault_route =
        src.first_analog_input_fault;
    assign next_msg.input_two_fault_route =
        src.second_analog_input_fault;
    assign next_msg.hours_limit  = src.hours_preset_reached;
    assign next_msg.cycles_limit = src.cycles_preset_reached;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            msg_q <= '0;
        end else if (ce) begin
            msg_q <= next_msg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter registers.

    localparam int N = `SER_MSG_COUNT;
    // Index i holds the offset of the enable for message bit i.
    localparam logic [15:0] EN_OFF [N] = '{
        `SER_OFF_CYCLES, `SER_OFF_HOURS, `SER_OFF_INPUT_TWO,
        `SER_OFF_INPUT_ONE, `SER_OFF_PROGRAM, `SER_OFF_COUNTDOWN,
        `SER_OFF_SHORT};

    logic [N-1:0]        en_q;
    logic [N-1:0]        en_hit;
    ser_pkg::ser_sense_t sense_q;
    wire                 sense_hit  = reg_addr == `SER_OFF_SENSE;
    wire                 status_hit = reg_addr == `SER_OFF_MSG_STATUS;

    // Only the lowest data bit is stored; the values are 0 or 1 by design.
    for (genvar i = 0; i < N; i++) begin : g_en
        assign en_hit[i] = reg_addr == EN_OFF[i];
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                en_q[i] <= `SER_RST_ENABLE;
            end else if (ce && reg_wr && en_hit[i]) begin
                en_q[i] <= reg_wdata[0];
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sense_q <= ser_pkg::ser_sense_t'(`SER_RST_SENSE);
        end else if (ce && reg_wr && sense_hit) begin
            sense_q <= ser_pkg::ser_sense_t'(reg_wdata[0]);
        end
    end

    // Unmapped offsets read as zero and ignore writes.
    wire        en_rd = |(en_hit & en_q);
    wire [15:0] next_rdata =
        status_hit ? {{(16-N){1'b0}}, msg_q} :
        {15'h0000, en_rd | (sense_hit & sense_q)};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output combination.

    wire [N-1:0] routed = msg_q & en_q;
    // The OR is taken on registered messages so a glitchy source never
    // reaches the relay driver directly; it costs one cycle of latency.
    wire         active = |routed;
    wire         next_out = active ^ (sense_q == ser_pkg::SER_SENSE_INVERSE);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            switch_out <= 1'b0;
        end else if (ce) begin
            switch_out <= next_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    ssr_alarm_a: assert property (
        ce |=> msg_q.short_circuit_route ==
               ($past(src.heat_current_sensed) & ~$past(src.ctrl_output_on)))
        else $error("short circuit alarm does not follow its cause");

    short_route_a: assert property (
        ce && !en_q[6] && en_q[5:0] == 6'h00 |-> !active)
        else $error("disabled short circuit alarm reaches the output");

    timer_msg_a: assert property (
        ce && !(src.timer_mode_cfg && src.timer_expired)
        |=> !msg_q.countdown_done)
        else $error("timer message without timer mode and elapsed time");

    timer_route_a: assert property (
        ce && en_q[5] && src.timer_mode_cfg && src.timer_expired
        && sense_q == ser_pkg::SER_SENSE_DIRECT
        ##1 ce && en_q[5] && sense_q == ser_pkg::SER_SENSE_DIRECT
        |=> switch_out)
        else $error("enabled timer message does not switch the output");

    program_msg_a: assert property (
        ce && src.program_done && !src.program_ctrl_cfg
        |=> !msg_q.program_finished)
        else $error("program end raised outside program mode");

    program_route_a: assert property (
        ce && !en_q[4] && en_q[6:5] == 2'b00 && en_q[3:0] == 4'h0 |-> !active)
        else $error("ignored program end still drives the output");

    input_fault_a: assert property (
        ce && src.first_analog_input_fault && en_q[3] ##1 ce && en_q[3]
        |-> active)
        else $error("first input fault not routed");

    input_two_a: assert property (
        ce && src.second_analog_input_fault && en_q[2] ##1 ce && en_q[2]
        |-> active)
        else $error("second input fault not routed");

    hours_info_a: assert property (
        ce && src.hours_preset_reached && en_q[1] ##1 ce && en_q[1] |-> active)
        else $error("hours preset status not routed");

    cycles_info_a: assert property (
        ce && src.cycles_preset_reached && en_q[0] ##1 ce && en_q[0] |-> active)
        else $error("cycles preset status not routed");

    sense_out_a: assert property (
        ce |=> switch_out == ($past(active) ^ $past(sense_q[0])))
        else $error("output does not follow active condition and sense");

    or_combine_a: assert property (
        ce && $countones(msg_q & en_q) != 0
        |=> switch_out == !$past(sense_q[0]))
        else $error("output inactive although an enabled message is set");

    enable_write_a: assert property (
        ce && reg_wr && reg_addr == `SER_OFF_COUNTDOWN
        |=> en_q[5] == $past(reg_wdata[0]))
        else $error("timer route enable write not stored");

    ssr_quiet_a: assert property (
        ce && src.ctrl_output_on
        |=> !msg_q.short_circuit_route)
        else $error("short circuit alarm while controller output is on");

    short_on_a: assert property (
        ce && en_q[6] && msg_q.short_circuit_route
        |=> switch_out == !$past(sense_q[0]))
        else $error("enabled short circuit alarm does not switch output");

    short_off_a: assert property (
        ce && !en_q[6] && en_q[5:0] == 6'h00
        |=> switch_out == $past(sense_q[0]))
        else $error("disabled short circuit alarm changes the output");

    short_store_a: assert property (
        ce && reg_wr && reg_addr == `SER_OFF_SHORT
        |=> en_q[6] == $past(reg_wdata[0]))
        else $error("short circuit route enable write not stored");

    timer_set_a: assert property (
        ce && src.timer_mode_cfg && src.timer_expired
        |=> msg_q.countdown_done)
        else $error("elapsed timer in timer mode gives no message");

    timer_read_a: assert property (
        ce && reg_addr == `SER_OFF_COUNTDOWN
        |=> reg_rdata == {15'h0000, $past(en_q[5])})
        else $error("timer route enable reads back wrong");

    program_set_a: assert property (
        ce && src.program_ctrl_cfg && src.program_done
        |=> msg_q.program_finished)
        else $error("finished program gives no program end message");

    program_on_a: assert property (
        ce && en_q[4] && msg_q.program_finished
        |=> switch_out == !$past(sense_q[0]))
        else $error("enabled program end does not switch the output");

    program_store_a: assert property (
        ce && reg_wr && reg_addr == `SER_OFF_PROGRAM
        |=> en_q[4] == $past(reg_wdata[0]))
        else $error("program end route enable write not stored");

    input_one_msg_a: assert property (
        ce
        |=> msg_q.input_one_fault_route == $past(src.first_analog_input_fault))
        else $error("first input fault message does not follow the fault");

    input_one_store_a: assert property (
        ce && reg_wr && reg_addr == `SER_OFF_INPUT_ONE
        |=> en_q[3] == $past(reg_wdata[0]))
        else $error("first input fault route enable write not stored");

    input_two_msg_a: assert property (
        ce
        |=> msg_q.input_two_fault_route == $past(src.second_analog_input_fault))
        else $error("second input fault message does not follow the fault");

    input_two_store_a: assert property (
        ce && reg_wr && reg_addr == `SER_OFF_INPUT_TWO
        |=> en_q[2] == $past(reg_wdata[0]))
        else $error("second input fault route enable write not stored");

    hours_msg_a: assert property (
        ce
        |=> msg_q.hours_limit == $past(src.hours_preset_reached))
        else $error("hours status does not follow its preset flag");

    hours_store_a: assert property (
        ce && reg_wr && reg_addr == `SER_OFF_HOURS
        |=> en_q[1] == $past(reg_wdata[0]))
        else $error("hours route enable write not stored");

    cycles_msg_a: assert property (
        ce
        |=> msg_q.cycles_limit == $past(src.cycles_preset_reached))
        else $error("cycles status does not follow its preset flag");

    cycles_store_a: assert property (
        ce && reg_wr && reg_addr == `SER_OFF_CYCLES
        |=> en_q[0] == $past(reg_wdata[0]))
        else $error("cycles route enable write not stored");

    sense_store_a: assert property (
        ce && reg_wr && reg_addr == `SER_OFF_SENSE
        |=> sense_q[0] == $past(reg_wdata[0]))
        else $error("operating sense write not stored");

    idle_out_a: assert property (
        ce && en_q == 7'h00
        |=> switch_out == $past(sense_q[0]))
        else $error("output leaves its idle level with no route enabled");

    status_read_a: assert property (
        ce && status_hit
        |=> reg_rdata == {9'h000, $past(msg_q)})
        else $error("message status reads back wrong");

    // A low enable must freeze everything, the readback word included.
    freeze_hold_a: assert property (
        !ce
        |=> $stable(switch_out) && $stable(en_q) && $stable(msg_q)
            && $stable(reg_rdata) && $stable(sense_q))
        else $error("state changed while the clock enable was low");

    ////////////////////////////////////////////////////////////////////////
    // Cover points.

    short_cover_c: cover property (
        ce && en_q[6] && msg_q.short_circuit_route ##1 ce && switch_out);
    inverse_cover_c: cover property (
        ce && sense_q == ser_pkg::SER_SENSE_INVERSE && active);
    readback_cover_c: cover property (
        ce && status_hit && msg_q != '0);
    timer_cover_c: cover property (
        ce && en_q[5] && msg_q.countdown_done);
    freeze_cover_c: cover property (!ce ##1 ce);

endmodule

/* dv/ser_host.sv */
// Fieldbus master model that writes and reads the router parameters.
`timescale 1ns/10ps

module ser_host (
    input  wire logic        mclk,
    output logic      [15:0] reg_addr,
    output logic             reg_wr,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr  = 16'h0000;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Released write data is inverted, so a stale word is never trusted.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        #1;
        d = reg_rdata;
    endtask
endmodule

/* dv/tb_ser_router.sv */
// Self-checking bench of the switching output event router.
`timescale 1ns/10ps
`include "ser_regs.svh"

module tb_ser_router;
    logic              mclk   = 1'b0;
    logic              arst_n = 1'b0;
    logic              ce     = 1'b1;
    ser_pkg::ser_src_t src    = 10'h0a0;
    logic [15:0]       reg_addr;
    logic              reg_wr;
    logic [15:0]       reg_wdata;
    logic [15:0]       reg_rdata;
    logic              switch_out;
    logic [15:0]       rv;
    int                n_fail  = 0;
    int                n_tests = 0;
    wire logic [15:0]  so = {15'h0000, switch_out};
    logic [15:0]       offs [7] = '{`SER_OFF_SHORT, `SER_OFF_COUNTDOWN,
        `SER_OFF_PROGRAM, `SER_OFF_INPUT_ONE, `SER_OFF_INPUT_TWO,
        `SER_OFF_HOURS, `SER_OFF_CYCLES};
    // Each message with its configuration qualifiers already satisfied.
    logic [9:0]        evs [7] = '{10'h200, 10'h0c0, 10'h030, 10'h008,
        10'h004, 10'h002, 10'h001};

    always #5 mclk = ~mclk;

    ser_router u_dut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .src(src),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .switch_out(switch_out));
    ser_host u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    // Output follows the source two edges later, so that wait is fixed.
    task automatic ev(input logic [9:0] s, input logic e);
        @(posedge mclk);
        src <= ser_pkg::ser_src_t'(s);
        repeat (2) @(posedge mclk);
        #1;
        chk(so, {15'h0000, e});
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int i = 0; i < 7; i++) begin
            u_host.rd(offs[i], rv);
            chk(rv, 16'h0000);
            u_host.wr(offs[i], 16'hfffe);
            u_host.rd(offs[i], rv);
            chk(rv, 16'h0000);
            u_host.wr(offs[i], 16'h0001);
            u_host.rd(offs[i], rv);
            chk(rv, 16'h0001);
            u_host.wr(offs[i], 16'h0000);
        end
        u_host.wr(16'h03d8, 16'h0001);
        u_host.rd(16'h03d8, rv);
        chk(rv, 16'h0000);
    endtask

    task automatic t_route();
        for (int i = 0; i < 7; i++) begin
            ev(evs[i], 1'b0);
            u_host.wr(offs[i], 16'h0001);
            ev(evs[i], 1'b1);
            ev(10'h0a0, 1'b0);
            u_host.wr(offs[i], 16'h0000);
        end
    endtask

    task automatic t_gate();
        for (int i = 0; i < 7; i++) begin
            u_host.wr(offs[i], 16'h0001);
        end
        ev(10'h040, 1'b0);
        ev(10'h010, 1'b0);
        ev(10'h300, 1'b0);
        ev(10'h200, 1'b1);
        u_host.rd(`SER_OFF_MSG_STATUS, rv);
        chk(rv, 16'h0040);
        ev(10'h00c, 1'b1);
        u_host.rd(`SER_OFF_MSG_STATUS, rv);
        chk(rv, 16'h000c);
        ev(10'h004, 1'b1);
        ev(10'h000, 1'b0);
    endtask

    task automatic t_sense();
        u_host.wr(`SER_OFF_SENSE, 16'h0001);
        ev(10'h000, 1'b1);
        ev(10'h008, 1'b0);
        u_host.wr(`SER_OFF_SENSE, 16'h0000);
        ev(10'h008, 1'b1);
    endtask

    // A low enable holds the output although its cause has gone.
    task automatic t_freeze();
        @(posedge mclk);
        ce  <= 1'b0;
        src <= ser_pkg::ser_src_t'(10'h000);
        repeat (3) @(posedge mclk);
        #1;
        chk(so, 16'h0001);
        @(posedge mclk);
        ce <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk(so, 16'h0000);
    endtask

    // Reset in mid-run drops the output and clears enables and sense.
    task automatic t_reset();
        u_host.wr(`SER_OFF_SENSE, 16'h0001);
        ev(10'h000, 1'b1);
        @(posedge mclk);
        arst_n <= 1'b0;
        @(posedge mclk);
        #1;
        chk(so, 16'h0000);
        @(posedge mclk);
        arst_n <= 1'b1;
        ev(10'h008, 1'b0);
        u_host.rd(`SER_OFF_SENSE, rv);
        chk(rv, 16'h0000);
        u_host.rd(`SER_OFF_INPUT_ONE, rv);
        chk(rv, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_route();
        t_gate();
        t_sense();
        t_freeze();
        t_reset();
        wrap_up();
    end

    // A hang is cut short here and counted against the run.
    initial begin
        #200us;
        n_fail++;
        wrap_up();
    end
endmodule
